// File: logic/fbc_ctrl.sv
// Overview of operation
// - Stable bit set freezes fine value after fine lock, else fine tracks.
// - Control bit 2 picks open loop (0) or closed loop (1).
// - Enable reads back at once; oscillator enable follows after sync.
// - Difference field shows ideal minus counted cycles, closed loop only.
// - Coarse field is writable in open loop, read-only in closed loop.
// - Fine field is writable in open loop, read-only in closed loop.
// - Multiplier bits 31:26 cap the coarse step per correction.
// - Multiplier bits 25:16 cap the fine step per correction.
// - Multiply factor is the ideal output cycles per reference period.
// - Writing multiply factor drops both locks and centres fine value.
// - Read request copies loop values and raises the ready flag together, after the sync wait.
// - Threshold field sets trigger level, loaded from user row at start.
// - Prescaler divides the 1 kHz clock by two to the field plus one.
// - Sampling clock enable starts or stops clock; reads show its state.
// - Mode bit picks continuous (0) or prescaled sampling (1).
// - Standby bit keeps detector alive in standby, else it is off.
// - Action field picks nothing, reset or interrupt on low supply.
// - Hysteresis bit turns on comparator hysteresis, loaded at start.
// - Enable bit turns the detector on, loaded from user row at start.
//
// The plain strobed port was chosen for this implementation.
`include "fbc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module fbc_ctrl
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Reference counter
    input wire logic meas_valid_i,
    input wire logic [15:0] meas_count_i,
    // Oscillator trim
    output logic loop_enable_o,
    output logic [5:0] loop_coarse_o,
    output logic [9:0] loop_fine_o,
    // User row values
    input wire logic [5:0] nvm_bod_level_i,
    input wire logic [1:0] nvm_bod_action_i,
    input wire logic nvm_bod_threshold_hysteresis_i,
    input wire logic nvm_bod_enable_i,
    // Asynchronous inputs
    input wire logic ulp_clk_1k_i,
    input wire logic supply_below_i,
    input wire logic standby_i,
    // Detector outputs
    output logic [5:0] bod_level_o,
    output logic bod_threshold_hysteresis_o,
    output logic bod_compare_en_o,
    output logic bod_reset_req_o,
    output logic bod_irq_o
);

    // Control and loop state
    logic [15:0] ctrl, next_ctrl;
    logic [1:0] en_pipe, next_en_pipe;
    logic [15:0] loop_ratio_difference, next_loop_ratio_difference;
    logic [5:0] loop_coarse, next_loop_coarse;
    logic [9:0] loop_fine, next_loop_fine;
    logic coarse_lock, next_coarse_lock;
    logic fine_lock, next_fine_lock;
    logic [15:0] val_ratio_difference, next_val_ratio_difference;
    logic [5:0] val_coarse, next_val_coarse;
    logic [9:0] val_fine, next_val_fine;
    logic [31:0] mul_reg, next_mul_reg;
    fbc_pkg::fbc_rq_e rq_state, next_rq_state;
    logic [1:0] rq_cnt, next_rq_cnt;
    logic ready, next_ready;
    logic [31:0] rdata, next_rdata;
    // Brown-out state
    logic loaded, next_loaded;
    logic [5:0] bod_level, next_bod_level;
    logic [3:0] bod_psel, next_bod_psel;
    logic bod_cen, next_bod_cen;
    logic cen_stat, next_cen_stat;
    logic bod_mode, next_bod_mode;
    logic bod_run_in_standby, next_bod_run_in_standby;
    logic [1:0] bod_action, next_bod_action;
    logic bod_threshold_hysteresis, next_bod_threshold_hysteresis;
    logic bod_enable, next_bod_enable;
    logic [15:0] ps_cnt, next_ps_cnt;
    logic tick, next_tick;
    logic rst_req, next_rst_req;
    logic irq, next_irq;
    logic ulp_prev, next_ulp_prev;
    // Synchronisers
    logic [2:0] sync_a;
    logic [3:0] sync_b;

    // Write strobes
    logic wr_ctrl, wr_val, wr_mul, wr_sync, wr_bod;
    logic closed, meas_upd, copy, ulp_rise, bod_active, bod_evt;

    function automatic logic [15:0] fbc_abs(input logic [15:0] d);
        fbc_abs = d[15] ? 16'(-d) : d;
    endfunction

    function automatic logic fbc_hit(input logic [7:0] a, input logic [7:0] o);
        fbc_hit = (a == o);
    endfunction

    function automatic logic [15:0] fbc_div_mask(input logic [3:0] p);
        fbc_div_mask = 16'(((16'h0001 << p) << 1) - 16'h0001);
    endfunction

    assign wr_ctrl = reg_wr_i && fbc_hit(reg_addr_i, `FBC_OFS_CTRL);
    assign wr_val = reg_wr_i && fbc_hit(reg_addr_i, `FBC_OFS_VALUE);
    assign wr_mul = reg_wr_i && fbc_hit(reg_addr_i, `FBC_OFS_MUL);
    assign wr_sync = reg_wr_i && fbc_hit(reg_addr_i, `FBC_OFS_SYNC);
    assign wr_bod = reg_wr_i && fbc_hit(reg_addr_i, `FBC_OFS_BOD);
    assign closed = ctrl[`FBC_CTRL_MODE];
    assign meas_upd = meas_valid_i && closed && loop_enable_o;
    assign copy = (rq_state == fbc_pkg::FBC_RQ_DONE);
    // Sync stage 2 outputs only
    assign ulp_rise = sync_a[2] && !ulp_prev;
    assign bod_active = bod_enable && (!sync_b[3] || bod_run_in_standby);
    assign bod_evt = bod_active && sync_b[1] && (!bod_mode || tick);

    // Loop group
    always_comb
    begin
        logic [15:0] d;
        logic [15:0] ad;
        logic [5:0] cmag;
        logic [9:0] fmag;
        logic [6:0] c7;
        logic [10:0] f11;
        d = 16'h0000;
        ad = 16'h0000;
        cmag = 6'h00;
        fmag = 10'h000;
        c7 = 7'h00;
        f11 = 11'h000;
        next_ctrl = ctrl;
        next_en_pipe = {en_pipe[0], ctrl[`FBC_CTRL_ENABLE]};
        next_loop_ratio_difference = loop_ratio_difference;
        next_loop_coarse = loop_coarse;
        next_loop_fine = loop_fine;
        next_coarse_lock = coarse_lock;
        next_fine_lock = fine_lock;
        next_val_ratio_difference = val_ratio_difference;
        next_val_coarse = val_coarse;
        next_val_fine = val_fine;
        next_mul_reg = mul_reg;
        next_rq_state = rq_state;
        next_rq_cnt = rq_cnt;
        next_ready = ready;
        if (wr_ctrl)
        begin
            next_ctrl = reg_wdata_i[15:0] & `FBC_CTRL_RW_MASK;
        end
        if (meas_upd)
        begin
            d = 16'(mul_reg[`FBC_MUL_RANGE] - meas_count_i);
            ad = fbc_abs(d);
            next_loop_ratio_difference = d;
            if (!coarse_lock)
            begin
                cmag = (ad > {10'h000, mul_reg[`FBC_COARSE_MAX_STEP_RANGE]}) ?
                    mul_reg[`FBC_COARSE_MAX_STEP_RANGE] : ad[5:0];
                c7 = d[15] ? {1'b0, loop_coarse} - {1'b0, cmag} :
                    {1'b0, loop_coarse} + {1'b0, cmag};
                next_loop_coarse = !c7[6] ? c7[5:0] :
                    (d[15] ? 6'h00 : 6'h3f);
                next_coarse_lock = (ad <= `FBC_COARSE_WIN);
            end
            else if (!(ctrl[`FBC_CTRL_STABLE] && fine_lock))
            begin
                fmag = (ad > {6'h00, mul_reg[`FBC_FINE_MAX_STEP_RANGE]}) ?
                    mul_reg[`FBC_FINE_MAX_STEP_RANGE] : ad[9:0];
                f11 = d[15] ? {1'b0, loop_fine} - {1'b0, fmag} :
                    {1'b0, loop_fine} + {1'b0, fmag};
                next_loop_fine = !f11[10] ? f11[9:0] :
                    (d[15] ? 10'h000 : 10'h3ff);
                next_fine_lock = (ad <= `FBC_FINE_WIN);
            end
        end
        if (wr_val && !closed)
        begin
            next_loop_coarse = reg_wdata_i[`FBC_COARSE_RANGE];
            next_loop_fine = reg_wdata_i[`FBC_FINE_RANGE];
            next_val_coarse = reg_wdata_i[`FBC_COARSE_RANGE];
            next_val_fine = reg_wdata_i[`FBC_FINE_RANGE];
        end
        if (wr_mul)
        begin
            next_mul_reg = reg_wdata_i;
            next_coarse_lock = 1'b0;
            next_fine_lock = 1'b0;
            next_loop_fine = `FBC_FINE_MID;
            next_val_fine = `FBC_FINE_MID;
        end
        case (rq_state)
            fbc_pkg::FBC_RQ_IDLE:
            begin
                next_rq_cnt = 2'h0;
            end
            fbc_pkg::FBC_RQ_WAIT:
            begin
                next_rq_cnt = 2'(rq_cnt + 2'h1);
                if (rq_cnt == 2'(`FBC_SYNC_CYCLES - 2'h1))
                begin
                    next_rq_state = fbc_pkg::FBC_RQ_DONE;
                end
            end
            fbc_pkg::FBC_RQ_DONE:
            begin
                next_val_ratio_difference = loop_ratio_difference;
                next_val_coarse = loop_coarse;
                next_val_fine = loop_fine;
                next_ready = 1'b1;
                next_rq_state = fbc_pkg::FBC_RQ_IDLE;
            end
            default:
            begin
                next_rq_state = fbc_pkg::FBC_RQ_IDLE;
            end
        endcase
        if (wr_sync && reg_wdata_i[`FBC_SYNC_READ_REQUEST])
        begin
            // Restart; a copy in flight still sets ready this cycle
            next_rq_state = fbc_pkg::FBC_RQ_WAIT;
            next_rq_cnt = 2'h0;
            next_ready = copy;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            ctrl <= `FBC_CTRL_RST;
            en_pipe <= 2'h0;
            loop_ratio_difference <= 16'h0000;
            loop_coarse <= 6'h00;
            loop_fine <= 10'h000;
            coarse_lock <= 1'b0;
            fine_lock <= 1'b0;
            val_ratio_difference <= 16'h0000;
            val_coarse <= 6'h00;
            val_fine <= 10'h000;
            mul_reg <= 32'h0000_0000;
            rq_state <= fbc_pkg::FBC_RQ_IDLE;
            rq_cnt <= 2'h0;
            ready <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            en_pipe <= next_en_pipe;
            loop_ratio_difference <= next_loop_ratio_difference;
            loop_coarse <= next_loop_coarse;
            loop_fine <= next_loop_fine;
            coarse_lock <= next_coarse_lock;
            fine_lock <= next_fine_lock;
            val_ratio_difference <= next_val_ratio_difference;
            val_coarse <= next_val_coarse;
            val_fine <= next_val_fine;
            mul_reg <= next_mul_reg;
            rq_state <= next_rq_state;
            rq_cnt <= next_rq_cnt;
            ready <= next_ready;
        end
    end

    // Two-stage synchronisers for pins
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            sync_a <= 3'h0;
            sync_b <= 4'h0;
        end
        else
        begin
            sync_a <= {sync_a[1], ulp_clk_1k_i, 1'b0};
            sync_b <= {sync_b[2], standby_i, sync_b[0], supply_below_i};
        end
    end

    // Brown-out group
    always_comb
    begin
        next_loaded = 1'b1;
        next_bod_level = bod_level;
        next_bod_psel = bod_psel;
        next_bod_cen = bod_cen;
        next_cen_stat = cen_stat;
        next_bod_mode = bod_mode;
        next_bod_run_in_standby = bod_run_in_standby;
        next_bod_action = bod_action;
        next_bod_threshold_hysteresis = bod_threshold_hysteresis;
        next_bod_enable = bod_enable;
        next_ps_cnt = ps_cnt;
        next_tick = 1'b0;
        next_ulp_prev = sync_a[2];
        next_rst_req = 1'b0;
        next_irq = 1'b0;
        if (!loaded)
        begin
            next_bod_level = nvm_bod_level_i;
            next_bod_action = nvm_bod_action_i;
            next_bod_threshold_hysteresis = nvm_bod_threshold_hysteresis_i;
            next_bod_enable = nvm_bod_enable_i;
        end
        else if (wr_bod)
        begin
            next_bod_level = reg_wdata_i[`FBC_BOD_LEVEL_RANGE];
            next_bod_psel = reg_wdata_i[`FBC_BOD_PSEL_RANGE];
            next_bod_cen = reg_wdata_i[`FBC_BOD_CEN];
            next_bod_mode = reg_wdata_i[`FBC_BOD_MODE];
            next_bod_run_in_standby = reg_wdata_i[`FBC_BOD_RUN_IN_STANDBY];
            next_bod_action = reg_wdata_i[`FBC_BOD_ACTION_RANGE];
            next_bod_threshold_hysteresis = reg_wdata_i[`FBC_BOD_THRESHOLD_HYSTERESIS];
            next_bod_enable = reg_wdata_i[`FBC_BOD_ENABLE];
        end
        if (ulp_rise)
        begin
            // Clock state settles on a source edge
            next_cen_stat = bod_cen;
            if (cen_stat)
            begin
                if (ps_cnt == fbc_div_mask(bod_psel))
                begin
                    next_ps_cnt = 16'h0000;
                    next_tick = 1'b1;
                end
                else
                begin
                    next_ps_cnt = 16'(ps_cnt + 16'h0001);
                end
            end
            else
            begin
                next_ps_cnt = 16'h0000;
            end
        end
        if (bod_evt)
        begin
            next_rst_req = (bod_action == fbc_pkg::FBC_ACT_RESET);
            next_irq = (bod_action == fbc_pkg::FBC_ACT_IRQ);
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            loaded <= 1'b0;
            bod_level <= 6'h00;
            bod_psel <= 4'h0;
            bod_cen <= 1'b0;
            cen_stat <= 1'b0;
            bod_mode <= 1'b0;
            bod_run_in_standby <= 1'b0;
            bod_action <= 2'h0;
            bod_threshold_hysteresis <= 1'b0;
            bod_enable <= 1'b0;
            ps_cnt <= 16'h0000;
            tick <= 1'b0;
            rst_req <= 1'b0;
            irq <= 1'b0;
            ulp_prev <= 1'b0;
        end
        else
        begin
            loaded <= next_loaded;
            bod_level <= next_bod_level;
            bod_psel <= next_bod_psel;
            bod_cen <= next_bod_cen;
            cen_stat <= next_cen_stat;
            bod_mode <= next_bod_mode;
            bod_run_in_standby <= next_bod_run_in_standby;
            bod_action <= next_bod_action;
            bod_threshold_hysteresis <= next_bod_threshold_hysteresis;
            bod_enable <= next_bod_enable;
            ps_cnt <= next_ps_cnt;
            tick <= next_tick;
            rst_req <= next_rst_req;
            irq <= next_irq;
            ulp_prev <= next_ulp_prev;
        end
    end

    // Read data, one cycle after the strobe
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `FBC_OFS_STATUS: next_rdata = {28'h0000000, loop_enable_o,
                    fine_lock, coarse_lock, ready};
                `FBC_OFS_CTRL: next_rdata = {16'h0000, ctrl};
                `FBC_OFS_VALUE: next_rdata = {val_ratio_difference, val_coarse, val_fine};
                `FBC_OFS_MUL: next_rdata = mul_reg;
                `FBC_OFS_BOD: next_rdata = {10'h000, bod_level, bod_psel,
                    2'h0, cen_stat, bod_mode, 1'b0, bod_run_in_standby, 1'b0,
                    bod_action, bod_threshold_hysteresis, bod_enable, 1'b0};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            rdata <= 32'h0000_0000;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

    assign reg_rdata_o = rdata;
    assign loop_enable_o = en_pipe[1];
    assign loop_coarse_o = loop_coarse;
    assign loop_fine_o = loop_fine;
    assign bod_level_o = bod_level;
    assign bod_threshold_hysteresis_o = bod_threshold_hysteresis;
    assign bod_compare_en_o = bod_active && (!bod_mode || tick);
    assign bod_reset_req_o = rst_req;
    assign bod_irq_o = irq;

    // Checks
    localparam int RQ_MAX = 6;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    chk_enable_lag: assert property (
        ctrl[`FBC_CTRL_ENABLE] |-> ##2 loop_enable_o)
        else $error("oscillator enable did not follow control bit");
    chk_mul_unlock: assert property (
        wr_mul |=> !coarse_lock && !fine_lock && loop_fine == `FBC_FINE_MID)
        else $error("multiply write kept lock or fine value");
    chk_closed_ignore: assert property (
        wr_val && closed && !copy |=> $stable(val_coarse) && $stable(val_fine))
        else $error("calibration write taken in closed loop");
    chk_open_write: assert property (
        wr_val && !closed && !meas_upd |=>
        loop_coarse == $past(reg_wdata_i[`FBC_COARSE_RANGE]) &&
        loop_fine == $past(reg_wdata_i[`FBC_FINE_RANGE]))
        else $error("open loop calibration write lost");
    chk_ratio_difference_open: assert property (
        !closed && $past(!closed) |-> $stable(loop_ratio_difference))
        else $error("difference changed in open loop");
    chk_fine_frozen: assert property (
        ctrl[`FBC_CTRL_STABLE] && fine_lock && !wr_mul && !wr_val &&
        !wr_ctrl |=> $stable(loop_fine))
        else $error("fine value moved after lock while frozen");
    chk_coarse_cap: assert property (
        meas_upd && !coarse_lock && !wr_val && !wr_mul |=>
        fbc_abs(16'({10'h000, loop_coarse} - {10'h000, $past(loop_coarse)}))
        <= {10'h000, $past(mul_reg[31:26])})
        else $error("coarse step above limit");
    chk_fine_cap: assert property (
        meas_upd && coarse_lock && !wr_val && !wr_mul |=>
        fbc_abs(16'({6'h00, loop_fine} - {6'h00, $past(loop_fine)}))
        <= {6'h00, $past(mul_reg[25:16])})
        else $error("fine step above limit");
    chk_ready_time: assert property (
        wr_sync && reg_wdata_i[`FBC_SYNC_READ_REQUEST] |-> ##[1:RQ_MAX] ready)
        else $error("ready flag not raised after read request");
    chk_bod_reset: assert property (
        bod_evt && bod_action == fbc_pkg::FBC_ACT_RESET |=>
        bod_reset_req_o && !bod_irq_o)
        else $error("low supply reset not requested");
    chk_bod_standby: assert property (
        sync_b[3] && !bod_run_in_standby |-> !bod_compare_en_o && !bod_evt)
        else $error("detector active in standby");

    cov_read_done: cover property (wr_sync ##[1:RQ_MAX] ready);
    cov_fine_lock: cover property (meas_upd ##1 fine_lock);
    cov_bod_irq: cover property (bod_irq_o);
    cov_sample_tick: cover property (tick && bod_mode);

endmodule

`default_nettype wire

// File: include/fbc_params.svh
`ifndef FBC_PARAMS_SVH
`define FBC_PARAMS_SVH

// Register byte offsets
`define FBC_OFS_STATUS 8'h0c
`define FBC_OFS_CTRL 8'h24
`define FBC_OFS_VALUE 8'h28
`define FBC_OFS_MUL 8'h2c
`define FBC_OFS_SYNC 8'h30
`define FBC_OFS_BOD 8'h34

// Control reset value and fine centre value
`define FBC_CTRL_RST 16'h0080
`define FBC_FINE_MID 10'h200

// Loop control fields
`define FBC_CTRL_ENABLE 1
`define FBC_CTRL_MODE 2
`define FBC_CTRL_STABLE 3
`define FBC_CTRL_ONDEMAND 7
`define FBC_CTRL_RW_MASK 16'h039e

// Value and multiplier fields
`define FBC_RATIO_DIFFERENCE_RANGE 31:16
`define FBC_COARSE_RANGE 15:10
`define FBC_FINE_RANGE 9:0
`define FBC_COARSE_MAX_STEP_RANGE 31:26
`define FBC_FINE_MAX_STEP_RANGE 25:16
`define FBC_MUL_RANGE 15:0
`define FBC_SYNC_READ_REQUEST 7

// Brown-out fields
`define FBC_BOD_LEVEL_RANGE 21:16
`define FBC_BOD_PSEL_RANGE 15:12
`define FBC_BOD_CEN 9
`define FBC_BOD_MODE 8
`define FBC_BOD_RUN_IN_STANDBY 6
`define FBC_BOD_ACTION_RANGE 4:3
`define FBC_BOD_THRESHOLD_HYSTERESIS 2
`define FBC_BOD_ENABLE 1

// Status fields
`define FBC_STAT_READY 0
`define FBC_STAT_CLOCK 1
`define FBC_STAT_FLOCK 2
`define FBC_STAT_ENABLED 3

// Lock windows and crossing delays
`define FBC_COARSE_WIN 16'h0004
`define FBC_FINE_WIN 16'h0000
`define FBC_SYNC_CYCLES 2'h3

`endif

// File: include/fbc_pkg.sv
package fbc_pkg;

    typedef enum logic [1:0] {
        FBC_RQ_IDLE = 2'h0,
        FBC_RQ_WAIT = 2'h1,
        FBC_RQ_DONE = 2'h3
    } fbc_rq_e;

    typedef enum logic [1:0] {
        FBC_ACT_NONE = 2'h0,
        FBC_ACT_RESET = 2'h1,
        FBC_ACT_IRQ = 2'h2
    } fbc_action_e;

endpackage

// File: logic/fbc_unused_note_placeholder.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: testbench/fbc_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic meas_valid_i = 1'b0;
    logic [15:0] meas_count_i = 16'h0;
    logic loop_enable_o;
    logic [5:0] loop_coarse_o;
    logic [9:0] loop_fine_o;
    logic ulp_clk_1k_i = 1'b0;
    logic supply_below_i = 1'b0;
    logic standby_i = 1'b0;
    logic [5:0] bod_level_o;
    logic bod_threshold_hysteresis_o, bod_compare_en_o, bod_reset_req_o, bod_irq_o;
    int errors = 0;
    int total_checks = 0;

    fbc_ctrl dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .meas_valid_i(meas_valid_i), .meas_count_i(meas_count_i),
        .loop_enable_o(loop_enable_o), .loop_coarse_o(loop_coarse_o),
        .loop_fine_o(loop_fine_o), .nvm_bod_level_i(6'h15),
        .nvm_bod_action_i(2'h1), .nvm_bod_threshold_hysteresis_i(1'b1),
        .nvm_bod_enable_i(1'b1), .ulp_clk_1k_i(ulp_clk_1k_i),
        .supply_below_i(supply_below_i), .standby_i(standby_i),
        .bod_level_o(bod_level_o), .bod_threshold_hysteresis_o(bod_threshold_hysteresis_o),
        .bod_compare_en_o(bod_compare_en_o),
        .bod_reset_req_o(bod_reset_req_o), .bod_irq_o(bod_irq_o)
    );

    always #4 clk_sys_i = ~clk_sys_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    // Collects detector pulses over n cycles
    task automatic watch(input int n, output logic r, output logic q);
        r = 1'b0;
        q = 1'b0;
        repeat (n)
        begin
            @(posedge clk_sys_i);
            #1 r = r | bod_reset_req_o;
            q = q | bod_irq_o;
        end
    endtask

    task automatic t_reset();
        rchk(8'h24, 32'h00000080);
        rchk(8'h2c, 32'h00000000);
        rchk(8'h28, 32'h00000000);
        rchk(8'h30, 32'h00000000);
        rchk(8'h44, 32'h00000000);
        rchk(8'h34, 32'h0015000e);
        chk(bod_level_o, 32'h15);
        chk(bod_threshold_hysteresis_o, 32'h1);
    endtask

    task automatic t_open();
        wr(8'h28, 32'hffff1523);
        rchk(8'h28, 32'h00001523);
        chk(loop_coarse_o, 32'h5);
        chk(loop_fine_o, 32'h123);
        wr(8'h2c, 32'h08010100);
        rchk(8'h2c, 32'h08010100);
        rchk(8'h28, 32'h00001600);
        chk(loop_fine_o, 32'h200);
    endtask

    task automatic t_closed();
        logic [31:0] d;
        wr(8'h24, 32'h00000006);
        #1 chk(loop_enable_o, 32'h0);
        rchk(8'h24, 32'h00000006);
        repeat (2) @(posedge clk_sys_i);
        #1 chk(loop_enable_o, 32'h1);
        wr(8'h28, 32'h0000ffff);
        @(posedge clk_sys_i);
        meas_valid_i <= 1'b1;
        meas_count_i <= 16'h00f0;
        @(posedge clk_sys_i);
        meas_valid_i <= 1'b0;
        @(posedge clk_sys_i);
        #1 chk(loop_coarse_o, 32'h7);
        wr(8'h30, 32'h00000080);
        d = 32'h0;
        for (int i = 0; i < 20 && d[0] !== 1'b1; i++)
            rd(8'h0c, d);
        chk(d[0], 32'h1);
        rchk(8'h28, 32'h00101e00);
    endtask

    task automatic t_bod();
        logic r, q;
        @(posedge clk_sys_i);
        supply_below_i <= 1'b1;
        watch(10, r, q);
        chk({r, q}, 32'h2);
        @(posedge clk_sys_i);
        standby_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        watch(10, r, q);
        chk({r, q}, 32'h0);
        wr(8'h34, 32'h00150052);
        watch(10, r, q);
        chk({r, q}, 32'h1);
        @(posedge clk_sys_i);
        supply_below_i <= 1'b0;
        standby_i <= 1'b0;
        wr(8'h34, 32'h00150302);
        rchk(8'h34, 32'h00150102);
        watch(20, r, q);
        chk(bod_compare_en_o, 32'h0);
        repeat (2)
        begin
            @(posedge clk_sys_i);
            ulp_clk_1k_i <= 1'b1;
            repeat (8) @(posedge clk_sys_i);
            ulp_clk_1k_i <= 1'b0;
            repeat (8) @(posedge clk_sys_i);
        end
        rchk(8'h34, 32'h00150302);
        @(posedge clk_sys_i);
        ulp_clk_1k_i <= 1'b1;
        r = 1'b0;
        repeat (8)
        begin
            @(posedge clk_sys_i);
            #1 r = r | bod_compare_en_o;
        end
        chk(r, 32'h1);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        errors++;
        test_done();
    end

    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        t_reset();
        t_open();
        t_closed();
        t_bod();
        test_done();
    end
endmodule
`default_nettype wire
